/* File: src/acs_sequencer.sv */
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Setting start bit with enable bit set begins exactly one conversion
// - Hardware clears start bit when conversion ends
// - Done flag set with result; software clears
// - Enabled done flag raises interrupt, rearmed by clear
// - Conversion spans eleven converter clocks
module acs_sequencer (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic cmp_hi,
  output logic sample_hold,
  output logic [9:0] dac_trial,
  output logic conv_irq
);
  import acs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] ctrl_ff;
  logic [7:0] irq_en_ff;
  logic [7:0] stat_ff;
  logic [7:0] mask_ff;
  logic [9:0] result_ff;
  logic [7:0] rdata_ff;
  logic irq_ff;
  logic sample_ff;
  logic [9:0] trial_ff;
  logic [8:0] div_ff;
  logic [3:0] slot_ff;
  logic [11:0] conv_cyc_ff;
  acs_state_e state_ff;
  acs_state_e nxt_state;
  logic [9:0] sar_trial;
  logic [9:0] sar_value;

  wire wr_ctrl = reg_wr && reg_addr == ACS_ADDR_CTRL;
  wire wr_ien = reg_wr && reg_addr == ACS_ADDR_IRQ_EN;
  wire wr_mask = reg_wr && reg_addr == ACS_ADDR_IRQ_MASK;
  wire rd_stat = reg_rd && reg_addr == ACS_ADDR_IRQ_STAT;
  wire adc_tick = div_ff == ACS_DIV_LAST;
  wire start_req = ctrl_ff[ACS_BIT_START] && ctrl_ff[ACS_BIT_ENABLE];
  wire last_slot = slot_ff == ACS_CONV_SLOTS - 4'h1;
  wire conv_done = state_ff == ACS_FINISH;
  wire sar_clear = state_ff == ACS_IDLE;
  wire sar_step = state_ff == ACS_RESOLVE && adc_tick;
  // Left aligned: high holds bits 9..2, low holds bits 1..0 in its top
  wire [7:0] res_high = result_ff[9:2];
  wire [7:0] res_low = {result_ff[1:0], 6'h00};
  wire done_rise = conv_done;
  wire [7:0] rd_mux;
  wire [7:0] ctrl_wr_val;

  // Done bit only clears on a write of zero; a write cannot set it
  assign ctrl_wr_val = {reg_wdata[7:5], reg_wdata[ACS_BIT_DONE] & ctrl_ff[ACS_BIT_DONE],
                        reg_wdata[3:0]};
  assign rd_mux = (reg_addr == ACS_ADDR_CTRL) ? ctrl_ff :
                  (reg_addr == ACS_ADDR_RES_HIGH) ? res_high :
                  (reg_addr == ACS_ADDR_RES_LOW) ? res_low :
                  (reg_addr == ACS_ADDR_IRQ_EN) ? irq_en_ff :
                  (reg_addr == ACS_ADDR_IRQ_STAT) ? stat_ff :
                  (reg_addr == ACS_ADDR_IRQ_MASK) ? mask_ff : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  acs_sar_reg u_sar (
    .clk_sys(clk_sys),
    .rst(rst),
    .clear(sar_clear),
    .step(sar_step),
    .cmp_hi(cmp_hi),
    .trial(sar_trial),
    .value(sar_value)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ACS_IDLE: if (start_req) nxt_state = ACS_SAMPLE;
      ACS_SAMPLE: if (adc_tick) nxt_state = ACS_RESOLVE;
      ACS_RESOLVE: if (adc_tick && last_slot) nxt_state = ACS_FINISH;
      ACS_FINISH: nxt_state = ACS_IDLE;
      default: nxt_state = ACS_IDLE;
    endcase
  end

  // Divider restarts with each conversion so every slot is a full period
  always_ff @(posedge clk_sys) begin
    if (rst || state_ff == ACS_IDLE) begin
      div_ff <= 9'h000;
      slot_ff <= 4'h0;
    end else if (adc_tick) begin
      div_ff <= 9'h000;
      slot_ff <= slot_ff + 4'h1;
    end else begin
      div_ff <= div_ff + 9'h001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_ff <= ACS_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Hardware events win over a software write in the same cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_ff <= ACS_RST_BYTE;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= ctrl_wr_val;
      end
      if (conv_done) begin
        ctrl_ff[ACS_BIT_START] <= 1'b0;
        ctrl_ff[ACS_BIT_DONE] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      result_ff <= 10'h000;
    end else if (conv_done) begin
      result_ff <= sar_value;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_en_ff <= ACS_RST_BYTE;
      mask_ff <= ACS_RST_BYTE;
    end else begin
      if (wr_ien) irq_en_ff <= reg_wdata;
      if (wr_mask) mask_ff <= reg_wdata;
    end
  end

  // Status bit 0: conversion finished; read clears, new event wins
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stat_ff <= ACS_RST_BYTE;
    end else if (done_rise) begin
      stat_ff[0] <= 1'b1;
    end else if (rd_stat) begin
      stat_ff <= ACS_RST_BYTE;
    end
  end

  // Level request follows the enabled done flag or any status bit set in the mask, so it rearms once software clears it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_ff <= 1'b0;
      rdata_ff <= 8'h00;
      sample_ff <= 1'b0;
      trial_ff <= 10'h000;
    end else begin
      irq_ff <= (ctrl_ff[ACS_BIT_DONE] && irq_en_ff[ACS_BIT_IRQ_EN]) ||
                (|(stat_ff & mask_ff));
      rdata_ff <= reg_rd ? rd_mux : 8'h00;
      sample_ff <= nxt_state == ACS_SAMPLE;
      trial_ff <= sar_trial;
    end
  end

  assign reg_rdata = rdata_ff;
  assign conv_irq = irq_ff;
  assign sample_hold = sample_ff;
  assign dac_trial = trial_ff;

  // Cycles since the sample slot began; a conversion is too long for a delay range
  always_ff @(posedge clk_sys) begin
    if (rst || state_ff == ACS_IDLE) begin
      conv_cyc_ff <= 12'h000;
    end else begin
      conv_cyc_ff <= conv_cyc_ff + 12'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  conv_len_a: assert property (@(posedge clk_sys) disable iff (rst)
    conv_done |-> conv_cyc_ff == ACS_CONV_CYC && slot_ff == ACS_CONV_SLOTS)
    else $error("Conversion length wrong");
  sample_len_a: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(sample_hold) |-> conv_cyc_ff == ACS_SLOT_CYC)
    else $error("Sample slot length wrong");
  result_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    !conv_done |=> $stable(result_ff))
    else $error("Result changed outside finish");
  start_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    conv_done |=> !ctrl_ff[ACS_BIT_START])
    else $error("Start bit not cleared");
  done_set_a: assert property (@(posedge clk_sys) disable iff (rst)
    conv_done |=> ctrl_ff[ACS_BIT_DONE] && result_ff == $past(sar_value))
    else $error("Done flag without result");
  done_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(ctrl_ff[ACS_BIT_DONE]) |-> $past(wr_ctrl))
    else $error("Done flag cleared by hardware");
  one_conv_a: assert property (@(posedge clk_sys) disable iff (rst)
    conv_done |=> state_ff == ACS_IDLE ##1 state_ff == ACS_IDLE || $past(start_req))
    else $error("Extra conversion started");
  start_go_a: assert property (@(posedge clk_sys) disable iff (rst)
    state_ff == ACS_IDLE && start_req |=> state_ff == ACS_SAMPLE)
    else $error("Start not taken");
  irq_req_a: assert property (@(posedge clk_sys) disable iff (rst)
    ctrl_ff[ACS_BIT_DONE] && irq_en_ff[ACS_BIT_IRQ_EN] |=> conv_irq)
    else $error("Interrupt missing");
  irq_quiet_a: assert property (@(posedge clk_sys) disable iff (rst)
    !ctrl_ff[ACS_BIT_DONE] && stat_ff == 8'h00 |=> !conv_irq)
    else $error("Spurious interrupt");
endmodule
`default_nettype wire

/* File: src/acs_pkg.sv */
`default_nettype none
package acs_pkg;
  // Register offsets of the plain register port
  localparam logic [3:0] ACS_ADDR_CTRL = 4'h0;
  localparam logic [3:0] ACS_ADDR_RES_HIGH = 4'h1;
  localparam logic [3:0] ACS_ADDR_RES_LOW = 4'h2;
  localparam logic [3:0] ACS_ADDR_IRQ_EN = 4'h3;
  localparam logic [3:0] ACS_ADDR_IRQ_STAT = 4'h4;
  localparam logic [3:0] ACS_ADDR_IRQ_MASK = 4'h5;
  // Field positions in the converter control and interrupt enable registers
  localparam int ACS_BIT_ENABLE = 5;
  localparam int ACS_BIT_DONE = 4;
  localparam int ACS_BIT_START = 3;
  localparam int ACS_BIT_IRQ_EN = 1;
  localparam logic [7:0] ACS_RST_BYTE = 8'h00;
  // Converter clock at 700 kHz, derived from the 200 MHz system clock
  localparam int ACS_CLK_MHZ = 200;
  localparam int ACS_ADC_KHZ = 700;
  localparam int ACS_DIV_CYC = (ACS_CLK_MHZ * 1000) / ACS_ADC_KHZ;
  localparam logic [8:0] ACS_DIV_LAST = 9'(ACS_DIV_CYC - 1);
  // One sample slot plus ten resolve steps
  localparam int ACS_SAMPLE_SLOTS = 1;
  localparam int ACS_RES_BITS = 10;
  localparam logic [3:0] ACS_CONV_SLOTS = 4'(ACS_SAMPLE_SLOTS + ACS_RES_BITS);
  // System cycles of one slot and of a whole conversion
  localparam logic [11:0] ACS_SLOT_CYC = 12'(ACS_DIV_CYC);
  localparam logic [11:0] ACS_CONV_CYC = 12'(ACS_DIV_CYC * (ACS_SAMPLE_SLOTS + ACS_RES_BITS));
  typedef enum logic [1:0] {ACS_IDLE, ACS_SAMPLE, ACS_RESOLVE, ACS_FINISH} acs_state_e;
endpackage
`default_nettype wire

/* File: src/acs_sar_reg.sv */
`timescale 1ns/10ps
`default_nettype none
// Successive approximation register: one trial bit per step
module acs_sar_reg (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clear,
  input wire logic step,
  input wire logic cmp_hi,
  output logic [9:0] trial,
  output logic [9:0] value
);
  logic [9:0] value_ff;
  logic [9:0] bit_ff;
  always_ff @(posedge clk_sys) begin
    if (rst || clear) begin
      value_ff <= 10'h000;
      bit_ff <= 10'h200;
    end else if (step && bit_ff != 10'h000) begin
      if (cmp_hi) begin
        value_ff <= value_ff | bit_ff;
      end
      bit_ff <= bit_ff >> 1;
    end
  end
  assign trial = value_ff | bit_ff;
  assign value = value_ff;
endmodule
`default_nettype wire

/* File: sim/acs_analog_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Sample-and-hold plus comparator of the analog core
module acs_analog_model (
  input wire logic clk_sys,
  input wire logic sample_hold,
  input wire logic [9:0] dac_trial,
  input wire logic [9:0] level,
  output logic cmp_hi
);
  logic [9:0] held_ff = 10'h000;
  // Input only follows level while sampling, so late changes go unseen
  always_ff @(posedge clk_sys) begin
    if (sample_hold) begin
      held_ff <= level;
    end
  end
  // Input sits half a step above held code, so no trial ties with it
  assign cmp_hi = (dac_trial <= held_ff);
endmodule
`default_nettype wire

/* File: sim/adc_conversion_sequencer_test.sv */
`timescale 1ns/10ps
`default_nettype none
module adc_conversion_sequencer_test;
  import acs_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic cmp_hi;
  logic sample_hold;
  logic conv_irq;
  logic [9:0] dac_trial;
  logic [9:0] level = 10'h000;
  int error_cnt = 0;
  int compares = 0;
  int sh_cnt = 0;
  ////////////////////////////////////////////////////////////////////////
  acs_sequencer DUT (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cmp_hi(cmp_hi), .sample_hold(sample_hold), .dac_trial(dac_trial),
    .conv_irq(conv_irq));
  acs_analog_model core (.clk_sys(clk_sys), .sample_hold(sample_hold),
    .dac_trial(dac_trial), .level(level), .cmp_hi(cmp_hi));
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Counts sample slot cycles across the whole run
  always @(posedge clk_sys) begin
    if (sample_hold === 1'b1) sh_cnt <= sh_cnt + 1;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp, what);
  endtask
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // About 11000 cycles are needed; the limit leaves ample margin
  initial begin
    #200000;
    error_cnt++;
    $display("ERROR %0t: run timed out", $time);
    results();
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    rd(ACS_ADDR_CTRL, ACS_RST_BYTE, "ctrl reset");
    rd(ACS_ADDR_RES_HIGH, 8'h00, "high reset");
    rd(4'hf, 8'h00, "unmapped read");
    chk({7'h0, conv_irq}, 8'h00, "irq reset");
    $display("test reset done");
    wr(ACS_ADDR_CTRL, 8'h08);
    repeat (400) @(posedge clk_sys);
    rd(ACS_ADDR_CTRL, 8'h08, "start waits");
    chk(8'(sh_cnt), 8'h00, "sampled while disabled");
    wr(ACS_ADDR_CTRL, 8'h00);
    wr(ACS_ADDR_CTRL, 8'h20);
    repeat (800) @(posedge clk_sys);
    wr(ACS_ADDR_IRQ_EN, 8'h02);
    $display("test disabled start done");
    level <= 10'h2b5;
    wr(ACS_ADDR_CTRL, 8'h28);
    repeat (1500) @(posedge clk_sys);
    wr(ACS_ADDR_CTRL, 8'h28);
    repeat (1590) @(posedge clk_sys);
    rd(ACS_ADDR_CTRL, 8'h28, "busy near end");
    chk({7'h0, conv_irq}, 8'h00, "irq early");
    repeat (60) @(posedge clk_sys);
    rd(ACS_ADDR_CTRL, 8'h30, "ctrl after end");
    chk({7'h0, conv_irq}, 8'h01, "irq on done");
    rd(ACS_ADDR_RES_HIGH, 8'had, "result high");
    rd(ACS_ADDR_RES_LOW, 8'h40, "result low");
    chk(8'(sh_cnt == ACS_DIV_CYC), 8'h01, "sample slot");
    repeat (3300) @(posedge clk_sys);
    rd(ACS_ADDR_CTRL, 8'h30, "done kept");
    chk(8'(sh_cnt == ACS_DIV_CYC), 8'h01, "one conversion");
    $display("test conversion done");
    rd(ACS_ADDR_IRQ_STAT, 8'h01, "status set");
    rd(ACS_ADDR_IRQ_STAT, 8'h00, "status cleared");
    wr(ACS_ADDR_CTRL, 8'h20);
    rd(ACS_ADDR_CTRL, 8'h20, "done cleared");
    chk({7'h0, conv_irq}, 8'h00, "irq cleared");
    level <= 10'h0ff;
    wr(ACS_ADDR_CTRL, 8'h28);
    repeat (3200) @(posedge clk_sys);
    rd(ACS_ADDR_CTRL, 8'h30, "second done");
    chk({7'h0, conv_irq}, 8'h01, "irq rearmed");
    rd(ACS_ADDR_RES_HIGH, 8'h3f, "second high");
    rd(ACS_ADDR_RES_LOW, 8'hc0, "second low");
    $display("test rearm done");
    wr(ACS_ADDR_CTRL, 8'h20);
    wr(ACS_ADDR_IRQ_EN, 8'h00);
    rd(ACS_ADDR_IRQ_MASK, 8'h00, "mask reset");
    chk({7'h0, conv_irq}, 8'h00, "irq masked");
    wr(ACS_ADDR_IRQ_MASK, 8'h01);
    rd(ACS_ADDR_IRQ_MASK, 8'h01, "mask set");
    chk({7'h0, conv_irq}, 8'h01, "irq from status");
    rd(ACS_ADDR_IRQ_STAT, 8'h01, "second status");
    rd(ACS_ADDR_IRQ_STAT, 8'h00, "second status cleared");
    chk({7'h0, conv_irq}, 8'h00, "irq after status read");
    $display("test status mask done");
    results();
  end
endmodule
`default_nettype wire
